//--- rtl/prog_lock_pkg.sv
// Types of the program lock block.
// Assumes the constants header is included where offsets are needed.
package prog_lock_pkg;
  // Programmer pin mode, decoded from the select pins
  typedef enum logic [6:0] {
    MODE_IDLE = 7'b000_0001,
    MODE_PCODE = 7'b000_0010,
    MODE_VERIFY = 7'b000_0100,
    MODE_PENC = 7'b000_1000,
    MODE_PLB1 = 7'b001_0000,
    MODE_PLB2 = 7'b010_0000,
    MODE_RSIG = 7'b100_0000
  } mode_type;
endpackage

//--- rtl/prog_lock_regs.svh
// Constants of the program lock block: register map, fields, resets.
// Assumes a 32-bit AXI4-Lite slave with word-aligned registers.
`ifndef PROG_LOCK_REGS_SVH
`define PROG_LOCK_REGS_SVH
`define PL_STATUS_OFS   12'h000
`define PL_CONTROL_OFS  12'h004
`define PL_ST_LB1_BIT   0
`define PL_ST_LB2_BIT   1
`define PL_ST_EALAT_BIT 2
`define PL_ST_EAEFF_BIT 3
`define PL_ST_REFU_BIT  4
`define PL_CT_ERASE_BIT 0
`define PL_CT_CLRREF_BIT 1
`define PL_SIG_MAKER_ADR 13'h0030
`define PL_SIG_PART_ADR  13'h0031
`define PL_ERASED_BYTE   8'hFF
`define PL_LOCK_UNPROG   1'b1
`define PL_RESP_OKAY     2'b00
`define PL_RESP_SLVERR   2'b10
`define PL_SYNC_RST      28'h000_0000
`endif

//--- rtl/program_lock_encrypted_verify.sv
// Program store with encryption array, two lock bits and signature read.
// Assumes an external programmer on the pins and software on AXI4-Lite.
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`include "prog_lock_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module program_lock_encrypted_verify
  import prog_lock_pkg::*;
#(
  parameter int          CODE_AW = 13,
  parameter logic [7:0]  MAKER_ID = 8'h5A, // Arbitrary value
  parameter logic [7:0]  PART_ID  = 8'hA5  // Arbitrary value
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_B,
  // AXI4-Lite write channels
  input  wire logic [11:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // AXI4-Lite read channels
  input  wire logic [11:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // Programmer pins
  input  wire logic        PGM_ENABLE,
  input  wire logic [12:0] PGM_ADDR,
  input  wire logic [7:0]  PGM_DATA_IN,
  output logic [7:0]       PGM_DATA_OUT,
  output logic             PGM_DATA_OE,
  input  wire logic        PROGRAM_STROBE_B,
  input  wire logic        VERIFY_READ_STROBE_B,
  input  wire logic        PGM_LOCK_SELECT,
  input  wire logic        SIGNATURE_SELECT_A,
  input  wire logic        SIGNATURE_SELECT_B,
  // Access select pin and its effective level
  input  wire logic        EXTERNAL_ACCESS_SELECT_B,
  output logic             EXTERNAL_ACCESS_EFFECTIVE_B,
  // Core code-table read port
  input  wire logic        CODE_RD_VALID,
  input  wire logic [12:0] CODE_RD_ADDR,
  input  wire logic        CODE_RD_FROM_EXTERNAL,
  output logic [7:0]       CODE_RD_DATA,
  output logic             CODE_RD_DENIED
);

  // Storage and lock state
  logic [7:0]  code_q [0:(1<<CODE_AW)-1];
  logic [7:0]  enc_q  [0:31];
  logic        lb1_q;
  logic        lb2_q;
  // Pin synchroniser stages and filtered levels
  logic [27:0] s1_q;
  logic [27:0] s2_q;
  logic [27:0] s3_q;
  logic [27:0] filt_q;
  logic [27:0] filt_d;
  logic        f_en;
  logic        f_pstb_b;
  logic        f_vstb_b;
  logic        f_lsel;
  logic        f_siga;
  logic        f_sigb;
  logic        f_ea_b;
  logic [12:0] f_addr;
  logic [7:0]  f_data;
  logic        pstb_prev_q;
  logic        prog_pulse;
  mode_type    mode;
  // Access select latch
  logic        ea_cap_q;
  logic        ea_lat_q;
  // Protection decode
  logic        lock1_on;
  logic        verify_off;
  // Bus slave state
  logic        aw_got_q;
  logic        w_got_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        wr_fire;
  logic        erase_cmd;
  logic        clr_refused;
  logic        refused_q;
  logic [7:0]  vdata_q;
  logic        voe_q;
  logic [7:0]  crd_q;
  logic        cden_q;

  // Three-stage sync of all programmer pins
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      s1_q <= `PL_SYNC_RST;
      s2_q <= `PL_SYNC_RST;
      s3_q <= `PL_SYNC_RST;
    end else begin
      s1_q <= {PGM_ENABLE, PROGRAM_STROBE_B, VERIFY_READ_STROBE_B, PGM_LOCK_SELECT,
               SIGNATURE_SELECT_A, SIGNATURE_SELECT_B, EXTERNAL_ACCESS_SELECT_B,
               PGM_ADDR, PGM_DATA_IN};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A bit changes only when stages two and three agree
  assign filt_d = (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      filt_q      <= `PL_SYNC_RST;
      pstb_prev_q <= 1'b0;
    end else begin
      filt_q      <= filt_d;
      pstb_prev_q <= f_pstb_b;
    end
  end
  assign {f_en, f_pstb_b, f_vstb_b, f_lsel, f_siga, f_sigb, f_ea_b, f_addr, f_data} = filt_q;
  assign prog_pulse = pstb_prev_q & ~f_pstb_b;

  // Mode decode from select pins
  always_comb begin
    mode = MODE_IDLE;
    if (f_en) begin
      if (!f_pstb_b && f_vstb_b) begin
        case ({f_lsel, f_siga, f_sigb})
          3'b011:  mode = MODE_PCODE;
          3'b001:  mode = MODE_PENC;
          3'b111:  mode = MODE_PLB1;
          3'b100:  mode = MODE_PLB2;
          default: mode = MODE_IDLE;
        endcase
      end else if (f_pstb_b && !f_vstb_b && !f_lsel) begin
        case ({f_siga, f_sigb})
          2'b11:   mode = MODE_VERIFY;
          2'b00:   mode = MODE_RSIG;
          default: mode = MODE_IDLE;
        endcase
      end
    end
  end

  // Protection level; reserved combination behaves as unlocked
  assign lock1_on   = ~lb1_q;
  assign verify_off = ~lb1_q & ~lb2_q;

  // Command decode from a completed bus write
  assign wr_fire     = aw_got_q & w_got_q & ~bvalid_q;
  assign erase_cmd   = wr_fire && awaddr_q == `PL_CONTROL_OFS && wstrb_q[0]
                       && wdata_q[`PL_CT_ERASE_BIT];
  assign clr_refused = wr_fire && awaddr_q == `PL_CONTROL_OFS && wstrb_q[0]
                       && wdata_q[`PL_CT_CLRREF_BIT];

  // Code store: programming only clears bits, erase sets all
  always_ff @(posedge CLK) begin
    if (erase_cmd) begin
      for (int i = 0; i < (1 << CODE_AW); i++) begin
        code_q[i] <= `PL_ERASED_BYTE;
      end
    end else if (prog_pulse && mode == MODE_PCODE && !lock1_on) begin
      code_q[f_addr[CODE_AW-1:0]] <= code_q[f_addr[CODE_AW-1:0]] & f_data;
    end
  end

  // Encryption array and lock bits
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < 32; i++) begin
        enc_q[i] <= `PL_ERASED_BYTE;
      end
      lb1_q <= `PL_LOCK_UNPROG;
      lb2_q <= `PL_LOCK_UNPROG;
    end else if (erase_cmd) begin
      for (int i = 0; i < 32; i++) begin
        enc_q[i] <= `PL_ERASED_BYTE;
      end
      lb1_q <= `PL_LOCK_UNPROG;
      lb2_q <= `PL_LOCK_UNPROG;
    end else if (prog_pulse && !lock1_on) begin
      if (mode == MODE_PENC) begin
        enc_q[f_addr[4:0]] <= enc_q[f_addr[4:0]] & f_data;
      end
      if (mode == MODE_PLB1) begin
        lb1_q <= 1'b0;
      end
      if (mode == MODE_PLB2) begin
        lb2_q <= 1'b0;
      end
    end
  end

  // Sticky flag for refused programming; a new refusal beats the clear
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      refused_q <= 1'b0;
    end else if (prog_pulse && lock1_on && mode inside {MODE_PCODE, MODE_PENC,
                 MODE_PLB1, MODE_PLB2}) begin
      refused_q <= 1'b1;
    end else if (clr_refused) begin
      refused_q <= 1'b0;
    end
  end

  // Access select level caught once after reset release
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ea_cap_q <= 1'b0;
      ea_lat_q <= 1'b0;
    end else if (!ea_cap_q) begin
      ea_cap_q <= 1'b1;
      ea_lat_q <= EXTERNAL_ACCESS_SELECT_B;
    end
  end
  assign EXTERNAL_ACCESS_EFFECTIVE_B = lock1_on ? ea_lat_q : f_ea_b;

  // Verify and signature read-out on the data pins
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      vdata_q <= 8'h00;
      voe_q   <= 1'b0;
    end else if (mode == MODE_VERIFY && !verify_off) begin
      vdata_q <= ~(code_q[f_addr[CODE_AW-1:0]] ^ enc_q[f_addr[4:0]]);
      voe_q   <= 1'b1;
    end else if (mode == MODE_RSIG) begin
      if (f_addr == `PL_SIG_MAKER_ADR) begin
        vdata_q <= MAKER_ID;
      end else if (f_addr == `PL_SIG_PART_ADR) begin
        vdata_q <= PART_ID;
      end else begin
        vdata_q <= `PL_ERASED_BYTE;
      end
      voe_q <= 1'b1;
    end else begin
      vdata_q <= 8'h00;
      voe_q   <= 1'b0;
    end
  end
  assign PGM_DATA_OUT = vdata_q;
  assign PGM_DATA_OE  = voe_q;

  // Core code-table reads; external code cannot see internal bytes while lock bit 1 is programmed
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      crd_q  <= 8'h00;
      cden_q <= 1'b0;
    end else if (CODE_RD_VALID) begin
      if (lock1_on && CODE_RD_FROM_EXTERNAL) begin
        crd_q  <= 8'h00;
        cden_q <= 1'b1;
      end else begin
        crd_q  <= code_q[CODE_RD_ADDR[CODE_AW-1:0]];
        cden_q <= 1'b0;
      end
    end
  end
  assign CODE_RD_DATA   = crd_q;
  assign CODE_RD_DENIED = cden_q;

  // Write address and data taken independently
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (wr_fire) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
    end
  end
  assign S_AXI_AWREADY = ~aw_got_q & ~bvalid_q;
  assign S_AXI_WREADY  = ~w_got_q & ~bvalid_q;

  // Write response
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `PL_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (awaddr_q == `PL_CONTROL_OFS || awaddr_q == `PL_STATUS_OFS) ?
                  `PL_RESP_OKAY : `PL_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_q <= 1'b0;
    end
  end
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP  = bresp_q;

  // Read channel: status word, control reads zero
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `PL_RESP_OKAY;
    end else if (S_AXI_ARVALID && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `PL_RESP_OKAY;
      if (S_AXI_ARADDR == `PL_STATUS_OFS) begin
        rdata_q[`PL_ST_LB1_BIT]   <= lb1_q;
        rdata_q[`PL_ST_LB2_BIT]   <= lb2_q;
        rdata_q[`PL_ST_EALAT_BIT] <= ea_lat_q;
        rdata_q[`PL_ST_EAEFF_BIT] <= EXTERNAL_ACCESS_EFFECTIVE_B;
        rdata_q[`PL_ST_REFU_BIT]  <= refused_q;
      end else if (S_AXI_ARADDR != `PL_CONTROL_OFS) begin
        rresp_q <= `PL_RESP_SLVERR;
      end
    end else if (S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end
  assign S_AXI_ARREADY = ~rvalid_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;

endmodule
`default_nettype wire

//--- verification/pgm_programmer_model.sv
// Programmer model: drives mode, address and data pins, reads the byte.
// Assumes the bench calls one task at a time.
`timescale 1ns/1ps
`default_nettype none
module pgm_programmer_model #(
  parameter int STROBE_CYC = 4000
) (
  // Clock
  input wire logic        CLK,
  // Pins towards the device
  output logic            PGM_ENABLE,
  output logic [12:0]     PGM_ADDR,
  output logic [7:0]      PGM_DATA_IN,
  output logic            PROGRAM_STROBE_B,
  output logic            VERIFY_READ_STROBE_B,
  output logic            PGM_LOCK_SELECT,
  output logic            SIGNATURE_SELECT_A,
  output logic            SIGNATURE_SELECT_B,
  // Byte read back
  input wire logic [7:0]  PGM_DATA_OUT,
  input wire logic        PGM_DATA_OE
);
  // Idle pin levels
  initial begin
    PGM_ENABLE = 1'b1;
    PGM_ADDR = 13'h0000;
    PGM_DATA_IN = 8'h00;
    {PROGRAM_STROBE_B, VERIFY_READ_STROBE_B} = 2'h3;
    {PGM_LOCK_SELECT, SIGNATURE_SELECT_A, SIGNATURE_SELECT_B} = 3'h0;
  end
  // One programming operation with a low strobe pulse
  task automatic pulse(input logic [2:0] sel, input logic [12:0] a, input logic [7:0] d);
    @(posedge CLK);
    PGM_ADDR <= a;
    PGM_DATA_IN <= d;
    {PGM_LOCK_SELECT, SIGNATURE_SELECT_A, SIGNATURE_SELECT_B} <= sel;
    repeat (8) @(posedge CLK);
    PROGRAM_STROBE_B <= 1'b0;
    repeat (STROBE_CYC) @(posedge CLK);
    PROGRAM_STROBE_B <= 1'b1;
    repeat (8) @(posedge CLK);
    PGM_DATA_IN <= ~d; // Released data shows no stale byte
  endtask
  // Verify or signature read, returns enable and byte
  task automatic read(input logic sig, input logic [12:0] a, output logic [8:0] q);
    @(posedge CLK);
    PGM_ADDR <= a;
    {PGM_LOCK_SELECT, SIGNATURE_SELECT_A, SIGNATURE_SELECT_B} <= {1'b0, ~sig, ~sig};
    VERIFY_READ_STROBE_B <= 1'b0;
    repeat (8) @(posedge CLK);
    @(negedge CLK);
    q = {PGM_DATA_OE, PGM_DATA_OUT};
    @(posedge CLK);
    VERIFY_READ_STROBE_B <= 1'b1;
  endtask
endmodule
`default_nettype wire

//--- verification/prog_lock_checker_sva.sv
// Checker of the program lock block, bound to its top module.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module prog_lock_checker #(
  parameter int         CODE_AW  = 13,
  parameter logic [7:0] MAKER_ID = 8'h5A,
  parameter logic [7:0] PART_ID  = 8'hA5
) (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RST_B,
  // Write handshakes
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  // Programmer pins
  input wire logic        PGM_ENABLE,
  input wire logic [12:0] PGM_ADDR,
  input wire logic [7:0]  PGM_DATA_OUT,
  input wire logic        PGM_DATA_OE,
  input wire logic        PROGRAM_STROBE_B,
  input wire logic        VERIFY_READ_STROBE_B,
  input wire logic        PGM_LOCK_SELECT,
  input wire logic        SIGNATURE_SELECT_A,
  input wire logic        SIGNATURE_SELECT_B,
  // Access select and code-table port
  input wire logic        EXTERNAL_ACCESS_SELECT_B,
  input wire logic        EXTERNAL_ACCESS_EFFECTIVE_B,
  input wire logic        CODE_RD_VALID,
  input wire logic        CODE_RD_FROM_EXTERNAL,
  input wire logic [7:0]  CODE_RD_DATA,
  input wire logic        CODE_RD_DENIED
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  logic [18:0] pins_q;
  logic [3:0]  stable_q;
  wire logic [18:0] pins = {PGM_ENABLE, PGM_ADDR, PROGRAM_STROBE_B, VERIFY_READ_STROBE_B,
                            PGM_LOCK_SELECT, SIGNATURE_SELECT_A, SIGNATURE_SELECT_B};
  wire logic sig_mode = PGM_ENABLE && PROGRAM_STROBE_B && !VERIFY_READ_STROBE_B &&
                        !PGM_LOCK_SELECT && !SIGNATURE_SELECT_A && !SIGNATURE_SELECT_B;
  wire logic settled = stable_q >= 4'h6;
  // Cycles since the mode or address pins last moved, saturating
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pins_q   <= '0;
      stable_q <= 4'h0;
    end else begin
      pins_q   <= pins;
      stable_q <= (pins != pins_q) ? 4'h0 : (stable_q == 4'hF ? stable_q : stable_q + 4'h1);
    end
  end
  AST_SIG_MAKER: assert property (settled && sig_mode && PGM_ADDR == 13'h0030 |-> PGM_DATA_OE && PGM_DATA_OUT == MAKER_ID) else $error("maker byte wrong");
  AST_SIG_PART: assert property (settled && sig_mode && PGM_ADDR == 13'h0031 |-> PGM_DATA_OE && PGM_DATA_OUT == PART_ID) else $error("part byte wrong");
  AST_OUT_QUIET: assert property (!PGM_DATA_OE |-> PGM_DATA_OUT == 8'h00) else $error("byte while not driving");
  AST_DENY_ZERO: assert property (CODE_RD_DENIED |-> CODE_RD_DATA == 8'h00) else $error("denied read leaks");
  AST_INT_OK: assert property (CODE_RD_VALID && !CODE_RD_FROM_EXTERNAL |=> !CODE_RD_DENIED) else $error("internal read denied");
  AST_DENY_CAUSE: assert property ($rose(CODE_RD_DENIED) |-> $past(CODE_RD_VALID && CODE_RD_FROM_EXTERNAL)) else $error("denial without external read");
  AST_EA_FOLLOW: assert property ($changed(EXTERNAL_ACCESS_EFFECTIVE_B) |-> EXTERNAL_ACCESS_EFFECTIVE_B == $past(EXTERNAL_ACCESS_SELECT_B)) else $error("select moved alone");
  // Pair is registered at the taking edge and answered one edge later
  AST_B_AFTER_WR: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> ##1 S_AXI_BVALID) else $error("no write answer");
  // Main scenarios reached
  cover property (settled && sig_mode && PGM_DATA_OE);
  cover property ($rose(CODE_RD_DENIED));
  cover property (S_AXI_BVALID);
endmodule
bind program_lock_encrypted_verify prog_lock_checker #(.CODE_AW(CODE_AW), .MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) chk (.*);
`default_nettype wire

//--- verification/test_program_lock_encrypted_verify.sv
// Bench of the program lock block: bus, programmer pins, code-table port.
// Assumes the programmer model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "prog_lock_regs.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, e); end end
module test_program_lock_encrypted_verify
  import prog_lock_pkg::*;
;
  localparam logic [7:0] MAKER = 8'h6E; // Arbitrary value
  localparam logic [7:0] PART  = 8'h91; // Arbitrary value
  typedef struct packed {logic sig; logic [12:0] adr; logic [8:0] exp;} row_type;
  logic        CLK, RST_B, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic        S_AXI_RREADY, PGM_ENABLE, PROGRAM_STROBE_B, VERIFY_READ_STROBE_B, PGM_DATA_OE;
  logic        PGM_LOCK_SELECT, SIGNATURE_SELECT_A, SIGNATURE_SELECT_B, CODE_RD_DENIED;
  logic        EXTERNAL_ACCESS_SELECT_B, EXTERNAL_ACCESS_EFFECTIVE_B;
  logic        CODE_RD_VALID, CODE_RD_FROM_EXTERNAL;
  logic [11:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, q;
  logic [3:0]  S_AXI_WSTRB;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, r;
  logic [12:0] PGM_ADDR, CODE_RD_ADDR;
  logic [7:0]  PGM_DATA_IN, PGM_DATA_OUT, CODE_RD_DATA;
  logic [8:0]  v;
  row_type     rows [6];
  int          fails, compares;
  program_lock_encrypted_verify #(.CODE_AW(6), .MAKER_ID(MAKER), .PART_ID(PART)) DUT (.*);
  pgm_programmer_model prog (.*);
  // 40 MHz clock
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  // Verdict and end of run
  task automatic complete_run;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One bus transfer, held until its answer is sampled
  task automatic axi(input logic wr, input logic [11:0] a, input logic [31:0] d);
    logic aw, w, ar, done;
    done = 1'b0;
    @(posedge CLK);
    if (wr) begin
      {S_AXI_AWADDR, S_AXI_WDATA} <= {a, d};
      {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
    end else begin
      S_AXI_ARADDR <= a;
      {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
    end
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge CLK);
      aw = S_AXI_AWVALID && S_AXI_AWREADY;
      w = S_AXI_WVALID && S_AXI_WREADY;
      ar = S_AXI_ARVALID && S_AXI_ARREADY;
      done = wr ? S_AXI_BVALID : S_AXI_RVALID;
      r = wr ? S_AXI_BRESP : S_AXI_RRESP;
      q = S_AXI_RDATA;
      @(posedge CLK);
      if (aw) S_AXI_AWVALID <= 1'b0;
      if (w) S_AXI_WVALID <= 1'b0;
      if (ar) S_AXI_ARVALID <= 1'b0;
      if (done) {S_AXI_BREADY, S_AXI_RREADY} <= 2'h0;
    end
    if (!done) begin
      fails++;
      complete_run();
    end
  endtask
  // Code-table read from address 0
  task automatic code_rd(input logic ext, input logic [8:0] e);
    @(posedge CLK);
    {CODE_RD_VALID, CODE_RD_ADDR, CODE_RD_FROM_EXTERNAL} <= {1'b1, 13'h0000, ext};
    @(posedge CLK);
    CODE_RD_VALID <= 1'b0;
    @(negedge CLK);
    `CHK({CODE_RD_DENIED, CODE_RD_DATA}, e)
  endtask
  // Main sequence
  initial begin
    {RST_B, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 6'h00;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
    S_AXI_WSTRB = 4'hF;
    {EXTERNAL_ACCESS_SELECT_B, CODE_RD_VALID, CODE_RD_FROM_EXTERNAL} = 3'h0;
    CODE_RD_ADDR = 13'h0000;
    fails = 0;
    compares = 0;
    rows = '{'{1'b0, 13'h0000, 9'h13C}, '{1'b0, 13'h0001, 9'h10F}, '{1'b0, 13'h0021, 9'h155},
             '{1'b0, 13'h003F, 9'h1FF}, '{1'b1, 13'h0030, {1'b1, MAKER}},
             '{1'b1, 13'h0031, {1'b1, PART}}};
    repeat (12) @(posedge CLK);
    RST_B <= 1'b1;
    axi(1'b0, `PL_STATUS_OFS, 32'h0);
    `CHK(q[4:0], 5'h03)
    axi(1'b1, 12'h008, 32'h1);
    `CHK(r, `PL_RESP_SLVERR)
    axi(1'b1, `PL_CONTROL_OFS, 32'h1);
    `CHK(r, `PL_RESP_OKAY)
    prog.pulse(3'b011, 13'h0000, 8'h3C);
    prog.pulse(3'b011, 13'h0021, 8'hA5);
    prog.pulse(3'b001, 13'h0001, 8'h0F);
    // Ordinary verify and signature reads
    foreach (rows[i]) begin
      prog.read(rows[i].sig, rows[i].adr, v);
      `CHK(v, rows[i].exp)
    end
    code_rd(1'b1, 9'h03C);
    EXTERNAL_ACCESS_SELECT_B <= 1'b1;
    repeat (10) @(posedge CLK);
    `CHK(EXTERNAL_ACCESS_EFFECTIVE_B, 1'b1)
    EXTERNAL_ACCESS_SELECT_B <= 1'b0;
    prog.pulse(3'b111, 13'h0000, 8'h00);
    code_rd(1'b1, 9'h100);
    code_rd(1'b0, 9'h03C);
    EXTERNAL_ACCESS_SELECT_B <= 1'b1;
    repeat (10) @(posedge CLK);
    `CHK(EXTERNAL_ACCESS_EFFECTIVE_B, 1'b0)
    EXTERNAL_ACCESS_SELECT_B <= 1'b0;
    // Refused code byte and second lock bit
    prog.pulse(3'b011, 13'h0002, 8'h00);
    prog.pulse(3'b100, 13'h0000, 8'h00);
    axi(1'b0, `PL_STATUS_OFS, 32'h0);
    `CHK(q[4:0], 5'h12)
    prog.read(1'b0, 13'h0002, v);
    `CHK(v, 9'h1FF)
    axi(1'b1, `PL_CONTROL_OFS, 32'h3);
    axi(1'b0, `PL_STATUS_OFS, 32'h0);
    `CHK(q[4:0], 5'h03)
    prog.read(1'b0, 13'h0000, v);
    `CHK(v, 9'h1FF)
    prog.pulse(3'b100, 13'h0000, 8'h00);
    axi(1'b0, `PL_STATUS_OFS, 32'h0);
    `CHK(q[4:0], 5'h01)
    prog.read(1'b0, 13'h0000, v);
    `CHK(v, 9'h1FF)
    prog.pulse(3'b111, 13'h0000, 8'h00);
    prog.read(1'b0, 13'h0000, v);
    `CHK(v[8], 1'b0)
    prog.read(1'b1, 13'h0030, v);
    `CHK(v, {1'b1, MAKER})
    code_rd(1'b1, 9'h100);
    complete_run();
  end
endmodule
`default_nettype wire
